// ### shared/ipa_pkg.sv
// constants and types shared by the port access unit
// assumes a 32-bit data bus with four byte lanes and one dword address per bus cycle
`default_nettype none
package ipa_pkg;
  localparam int          IPA_PORT_ADDR_W = 16;
  localparam logic [31:0] IPA_PORT_MASK   = 32'h0000FFFF;
  localparam logic [31:0] IPA_DWORD_MASK  = 32'hFFFFFFFC;
  localparam logic [31:0] IPA_MEM_STEP    = 32'h00000004;
  localparam logic [15:0] IPA_PORT_STEP   = 16'h0004;
  localparam logic        IPA_MEM_LEVEL   = 1'b1;
  localparam logic        IPA_PORT_LEVEL  = 1'b0;
  localparam logic [7:0]  IPA_BE_BYTE     = 8'h01;
  localparam logic [7:0]  IPA_BE_WORD     = 8'h03;
  localparam logic [7:0]  IPA_BE_DWORD    = 8'h0F;
  localparam logic [31:0] IPA_DATA_BYTE   = 32'h000000FF;
  localparam logic [31:0] IPA_DATA_WORD   = 32'h0000FFFF;
  localparam logic [31:0] IPA_DATA_DWORD  = 32'hFFFFFFFF;
  localparam logic [1:0]  IPA_CYC_ONE     = 2'h1;
  localparam logic [1:0]  IPA_CYC_TWO     = 2'h2;

  typedef enum logic [1:0] {IPA_SZ_BYTE, IPA_SZ_WORD, IPA_SZ_DWORD} ipa_size_t;
  typedef enum logic [1:0] {IPA_IDLE, IPA_LOW, IPA_HIGH} ipa_state_t;
endpackage
`default_nettype wire

// ### core/ipa_byte_lanes.sv
// byte enables of one transfer over two adjacent dwords
// assumes size codes from ipa_pkg; offset is the byte address modulo four
`default_nettype none
module ipa_byte_lanes
  import ipa_pkg::*;
(
  input  wire logic [1:0] offset,
  input  wire ipa_size_t  size,
  output logic      [7:0] lanes,
  output logic            crosses
);
  logic [7:0] base;

  always_comb begin
    unique case (size)
      IPA_SZ_BYTE: base = IPA_BE_BYTE;
      IPA_SZ_WORD: base = IPA_BE_WORD;
      default:     base = IPA_BE_DWORD;
    endcase
    lanes   = base << offset;
    crosses = |lanes[7:4];
  end
endmodule
`default_nettype wire

// ### core/io_port_access_unit.sv
// port and memory access sequencer between the core and the system bus
// assumes the core holds each request until reqReady, and waits for rspValid
// before its next instruction; the bus holds busAck high for one cycle per cycle
//
// Contract
// - separate 64K byte port space
// - byte, word, dword transfers from consecutive ports
// - aligned word or dword: one bus cycle
// - unaligned transfers use an extra bus cycle; here only those that cross a dword boundary do, others take one cycle
// - port write completes before next instruction
// - indicator high memory, low port
// - port-cycle parity errors reported, never masked
// - data in low byte, word or dword
`default_nettype none
module io_port_access_unit
  import ipa_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire logic        reqWrite,
  input  wire logic        reqMem,
  input  wire ipa_size_t   reqSize,
  input  wire logic [31:0] reqAddr,
  input  wire logic [31:0] reqData,
  output logic             rspValid,
  output logic      [31:0] rspData,
  output logic             rspParErr,
  output logic             busCyc,
  output logic             busWr,
  output logic             busMemIo,
  output logic      [31:0] busAddr,
  output logic       [3:0] busBe,
  output logic      [31:0] busWdata,
  input  wire logic [31:0] busRdata,
  input  wire logic        busAck,
  input  wire logic        busParErr
);
  typedef struct packed {
    ipa_state_t  st;
    logic [31:0] addr;
    logic [63:0] data;
    logic [7:0]  be;
    logic [1:0]  off;
    ipa_size_t   size;
    logic        mem;
    logic        wr;
    logic        algn;
    logic [1:0]  cyc;
    logic        parErr;
    logic        busCyc;
    logic [31:0] busAddr;
    logic [3:0]  busBe;
    logic [31:0] busWdata;
    logic        rspValid;
    logic [31:0] rspData;
    logic        rspParErr;
  } ipa_vec_t;

  ipa_vec_t    q_r;
  ipa_vec_t    q_nxt;
  logic [1:0]  rstPipe_r;
  logic        rstN;
  logic [7:0]  reqLanes;
  logic        reqCross;
  logic [31:0] reqBase;
  logic [31:0] sizeMask;
  logic [63:0] gathered;
  logic [63:0] shifted;
  logic        take;
  logic        ackNow;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstN = rstPipe_r[1];

  ipa_byte_lanes u_lanes (
    .offset  (reqAddr[1:0]),
    .size    (reqSize),
    .lanes   (reqLanes),
    .crosses (reqCross)
  );

  // port numbers live in 16 bits; upper address bits are never driven for port cycles
  assign reqBase  = (reqMem ? reqAddr : (reqAddr & IPA_PORT_MASK)) & IPA_DWORD_MASK;
  assign reqReady = (q_r.st == IPA_IDLE);
  assign take     = reqValid && reqReady;
  assign ackNow   = q_r.busCyc && busAck;

  always_comb begin
    q_nxt    = q_r;
    sizeMask = IPA_DATA_DWORD;
    gathered = q_r.data;
    shifted  = 64'h0;
    q_nxt.rspValid = 1'b0;
    unique case (q_r.size)
      IPA_SZ_BYTE: sizeMask = IPA_DATA_BYTE;
      IPA_SZ_WORD: sizeMask = IPA_DATA_WORD;
      default:     sizeMask = IPA_DATA_DWORD;
    endcase
    unique case (q_r.st)
      IPA_IDLE: begin
        if (take) begin
          q_nxt.st     = IPA_LOW;
          q_nxt.addr   = reqBase;
          q_nxt.be     = reqLanes;
          q_nxt.off    = reqAddr[1:0];
          q_nxt.size   = reqSize;
          q_nxt.mem    = reqMem;
          q_nxt.wr     = reqWrite;
          q_nxt.algn   = ~reqCross;
          q_nxt.cyc    = 2'h0;
          q_nxt.parErr = 1'b0;
          // only the low byte, word or dword of the source moves
          q_nxt.data   = {32'h0, reqData} << {reqAddr[1:0], 3'h0};
          q_nxt.busCyc   = 1'b1;
          q_nxt.busAddr  = reqBase;
          q_nxt.busBe    = reqLanes[3:0];
          q_nxt.busWdata = q_nxt.data[31:0];
        end
      end
      IPA_LOW, IPA_HIGH: begin
        if (ackNow) begin
          q_nxt.cyc    = q_r.cyc + 2'h1;
          // parity is collected on every cycle, port cycles included
          q_nxt.parErr = q_r.parErr | busParErr;
          if (q_r.st == IPA_LOW) begin
            gathered[31:0] = busRdata;
          end else begin
            gathered[63:32] = busRdata;
          end
          q_nxt.data = gathered;
          if (q_r.st == IPA_LOW && (|q_r.be[7:4])) begin
            // unaligned: the upper dword goes in a second cycle, low half always first
            q_nxt.st      = IPA_HIGH;
            q_nxt.busAddr = q_r.mem ? (q_r.addr + IPA_MEM_STEP)
                                    : {16'h0, q_r.addr[15:0] + IPA_PORT_STEP};
            q_nxt.busBe    = q_r.be[7:4];
            q_nxt.busWdata = q_r.data[63:32];
          end else begin
            // every transfer ends here, aligned after its single cycle, crossing after its second; writes answer only now
            q_nxt.st        = IPA_IDLE;
            q_nxt.busCyc    = 1'b0;
            q_nxt.busBe     = 4'h0;
            q_nxt.rspValid  = 1'b1;
            shifted         = gathered >> {q_r.off, 3'h0};
            q_nxt.rspData   = q_r.wr ? 32'h0 : (shifted[31:0] & sizeMask);
            q_nxt.rspParErr = q_r.parErr | busParErr;
          end
        end
      end
      default: begin
        q_nxt.st     = IPA_IDLE;
        q_nxt.busCyc = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign rspValid  = q_r.rspValid;
  assign rspData   = q_r.rspData;
  assign rspParErr = q_r.rspParErr;
  assign busCyc    = q_r.busCyc;
  assign busWr     = q_r.wr;
  assign busMemIo  = q_r.mem ? IPA_MEM_LEVEL : IPA_PORT_LEVEL;
  assign busAddr   = q_r.busAddr;
  assign busBe     = q_r.busBe;
  assign busWdata  = q_r.busWdata;

  chk_port_range: assert property (@(posedge clk) disable iff (!rstN)
    (busCyc && !busMemIo) |-> (busAddr[31:16] == 16'h0))
    else $error("port cycle address beyond 16 bits");

  chk_byte_count: assert property (@(posedge clk) disable iff (!rstN)
    (take && reqSize == IPA_SZ_BYTE) |=> ($countones(busBe) == 1))
    else $error("byte transfer without exactly one lane");

  chk_aligned_single: assert property (@(posedge clk) disable iff (!rstN)
    (rspValid && q_r.algn) |-> (q_r.cyc == IPA_CYC_ONE))
    else $error("aligned transfer used more than one bus cycle");

  chk_unaligned_two: assert property (@(posedge clk) disable iff (!rstN)
    (rspValid && !q_r.algn) |-> (q_r.cyc == IPA_CYC_TWO))
    else $error("crossing transfer did not use two bus cycles");

  chk_cycle_hold: assert property (@(posedge clk) disable iff (!rstN)
    (busCyc && !busAck) |=> (busCyc && $stable(busAddr) && $stable(busBe)))
    else $error("bus cycle changed before acknowledge");

  chk_write_done: assert property (@(posedge clk) disable iff (!rstN)
    (rspValid && busWr) |-> ($past(busAck) && !busCyc))
    else $error("write answered before its last bus cycle ended");

  chk_space_level: assert property (@(posedge clk) disable iff (!rstN)
    take |=> (busCyc && busMemIo == $past(reqMem)))
    else $error("memory or port indicator does not follow the request");

  chk_parity_report: assert property (@(posedge clk) disable iff (!rstN)
    (ackNow && busParErr && !busMemIo && q_nxt.rspValid) |=> (rspValid && rspParErr))
    else $error("port cycle parity error not reported");

  chk_byte_zero_ext: assert property (@(posedge clk) disable iff (!rstN)
    (rspValid && q_r.size == IPA_SZ_BYTE) |-> (rspData[31:8] == 24'h0))
    else $error("byte input not in low byte");

  cov_unaligned_port_read: cover property (@(posedge clk) disable iff (!rstN)
    rspValid && !busWr && !busMemIo && !q_r.algn);
  cov_aligned_dword_write: cover property (@(posedge clk) disable iff (!rstN)
    rspValid && busWr && q_r.size == IPA_SZ_DWORD && q_r.algn);
  cov_port_parity: cover property (@(posedge clk) disable iff (!rstN)
    rspValid && rspParErr && !busMemIo);
endmodule
`default_nettype wire

// ### testbench/ipa_bus_model.sv
// behavioural bus target: port and memory decode with byte-lane storage
// assumes the unit holds busCyc and its qualifiers until busAck
`default_nettype none
module ipa_bus_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        perr,
  input  wire logic        busCyc,
  input  wire logic        busWr,
  input  wire logic        busMemIo,
  input  wire logic [31:0] busAddr,
  input  wire logic  [3:0] busBe,
  input  wire logic [31:0] busWdata,
  output logic      [31:0] busRdata,
  output logic             busAck,
  output logic             busParErr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [16];
  logic  [3:0] idx;
  int          waitCnt;
  // space bit keeps port and memory apart; only address bits 4:2 decode, so ports alias every 32 bytes
  assign idx = {busMemIo, busAddr[4:2]};
  initial begin
    busAck = 1'b0;
    busParErr = 1'b0;
    busRdata = 32'h0000_0000;
    waitCnt = 0;
  end
  always @(posedge clk) begin
    // released data lines invert so a stale value never matches
    busRdata <= ~busRdata;
    busAck <= 1'b0;
    busParErr <= 1'b0;
    // lanes land by address, so any order of split cycles gives the same store
    if (busCyc && busAck && busWr) begin
      for (int b = 0; b < 4; b++) begin
        if (busBe[b]) mem[idx][8*b +: 8] <= busWdata[8*b +: 8];
      end
    end
    if (busCyc && !busAck) begin
      waitCnt <= waitCnt + 1;
      if (waitCnt >= (slow ? 3 : 0)) begin
        busAck <= 1'b1;
        busParErr <= perr;
        busRdata <= mem[idx];
        waitCnt <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the port access unit
// assumes ipa_bus_model answers every bus cycle
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ipa_pkg::*;
  logic        clk, rst_b, reqValid, reqReady, reqWrite, reqMem, rspValid, rspParErr;
  logic        busCyc, busWr, busMemIo, busAck, busParErr, slow, perr;
  ipa_size_t   reqSize;
  logic [31:0] reqAddr, reqData, rspData, busAddr, busWdata, busRdata;
  logic  [3:0] busBe;
  int          errors, checks, cycles;
  io_port_access_unit u_io_port_access_unit (.clk(clk), .rst_b(rst_b), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqMem(reqMem), .reqSize(reqSize), .reqAddr(reqAddr),
    .reqData(reqData), .rspValid(rspValid), .rspData(rspData), .rspParErr(rspParErr), .busCyc(busCyc),
    .busWr(busWr), .busMemIo(busMemIo), .busAddr(busAddr), .busBe(busBe), .busWdata(busWdata),
    .busRdata(busRdata), .busAck(busAck), .busParErr(busParErr));
  ipa_bus_model u_ipa_bus_model (.clk(clk), .slow(slow), .perr(perr), .busCyc(busCyc), .busWr(busWr),
    .busMemIo(busMemIo), .busAddr(busAddr), .busBe(busBe), .busWdata(busWdata), .busRdata(busRdata),
    .busAck(busAck), .busParErr(busParErr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one request; counts acknowledged bus cycles and checks space and response
  task automatic xfer(input logic w, m, input ipa_size_t s, input logic [31:0] a, d, ed,
                      input int nc, input logic ep);
    int n;
    n = 0;
    reqValid = 1'b1; reqWrite = w; reqMem = m; reqSize = s; reqAddr = a; reqData = d;
    while (reqReady !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
    reqValid = 1'b0;
    for (int t = 0; t < 60 && rspValid !== 1'b1; t++) begin
      if (busCyc === 1'b1 && busAck === 1'b1) begin
        n++;
        cmp("busMemIo", m ? IPA_MEM_LEVEL : IPA_PORT_LEVEL, busMemIo);
        cmp("busWr", w, busWr);
        if (!m) cmp("busAddr high", 32'h0, busAddr & ~IPA_PORT_MASK);
      end
      @(posedge clk) #1;
    end
    cmp("rspValid", 1, rspValid);
    cmp("bus cycles", nc, n);
    cmp("rspParErr", ep, rspParErr);
    if (!w) cmp("rspData", ed, rspData);
    else cmp("rspData write", 32'h0, rspData);
  endtask
  task automatic t_aligned();
    xfer(1, 0, IPA_SZ_DWORD, 32'h10, 32'h1122_3344, 0, 1, 0);
    xfer(0, 0, IPA_SZ_DWORD, 32'h10, 0, 32'h1122_3344, 1, 0);
    xfer(0, 0, IPA_SZ_WORD, 32'h12, 0, 32'h0000_1122, 1, 0);
  endtask
  task automatic t_spaces();
    xfer(1, 1, IPA_SZ_DWORD, 32'h10, 32'hAABB_CCDD, 0, 1, 0);
    xfer(0, 0, IPA_SZ_BYTE, 32'h11, 0, 32'h0000_0033, 1, 0);
    xfer(0, 1, IPA_SZ_DWORD, 32'h10, 0, 32'hAABB_CCDD, 1, 0);
    // memory crossing steps by four bytes, not by the port wrap
    xfer(1, 1, IPA_SZ_WORD, 32'h17, 32'h0000_7788, 0, 2, 0);
    xfer(0, 1, IPA_SZ_WORD, 32'h17, 0, 32'h0000_7788, 2, 0);
  endtask
  task automatic t_unaligned();
    slow = 1'b1;
    xfer(1, 0, IPA_SZ_WORD, 32'h3, 32'h0000_5566, 0, 2, 0);
    xfer(0, 0, IPA_SZ_WORD, 32'h3, 0, 32'h0000_5566, 2, 0);
    slow = 1'b0;
  endtask
  task automatic t_wrap();
    xfer(1, 0, IPA_SZ_DWORD, 32'h0001_FFFE, 32'hCAFE_F00D, 0, 2, 0);
    xfer(0, 0, IPA_SZ_DWORD, 32'hFFFE, 0, 32'hCAFE_F00D, 2, 0);
  endtask
  task automatic t_parity();
    perr = 1'b1;
    xfer(0, 0, IPA_SZ_BYTE, 32'h10, 0, 32'h0000_0044, 1, 1);
    perr = 1'b0;
    xfer(0, 0, IPA_SZ_BYTE, 32'h10, 0, 32'h0000_0044, 1, 0);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    errors = 0; checks = 0; cycles = 0; slow = 1'b0; perr = 1'b0;
    rst_b = 1'b0; reqValid = 1'b0; reqWrite = 1'b0; reqMem = 1'b0; reqSize = IPA_SZ_BYTE;
    reqAddr = 32'h0; reqData = 32'h0;
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_aligned();
    t_spaces();
    t_unaligned();
    t_wrap();
    t_parity();
    end_sim();
  end
endmodule
`default_nettype wire
